// ===== shared/chain_pkg.sv
// Constants shared by the command chaining queue and its two-entry FIFO.
// Assumes a single 10 MHz device clock and a synchronous active-low reset.
package chain_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;  // Device clock period
  localparam int IRQ_GAP_NS    = 200;  // Least interrupt-inactive time
  // Least time rounds up to whole cycles, never below one
  localparam int IRQ_GAP_RAW   = (IRQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IRQ_GAP_CYC   = (IRQ_GAP_RAW < 1) ? 1 : IRQ_GAP_RAW;
  localparam int GAP_W         = 2;    // Width of the gap counters
  localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(IRQ_GAP_CYC);

  // ---------------------------------------------------------------
  // Queue layout
  // ---------------------------------------------------------------
  localparam int PAGE_W      = 3;      // Page number width
  localparam int QUEUE_DEPTH = 2;      // Entries per direction
  localparam int CNT_W       = 2;      // Occupancy counter width
  localparam logic [CNT_W-1:0] CNT_RST  = 2'h0;   // Empty after reset
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(QUEUE_DEPTH);

endpackage

// ===== sim/net_engine_model.sv
// Behavioural network engine facing the chaining queue's engine side.
// Assumes one device clock; the bench asks for receptions via i_rx_go.
`timescale 1ns/1ps
module net_engine_model (
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  input  wire logic i_tx_start,  // Start request from the queue
  input  wire logic i_ack_val,   // Outcome to report for this frame
  input  wire logic i_rx_go,     // A packet addressed to us arrives
  input  wire logic i_rx_armed,  // Queue has a page ready
  output logic      o_tx_done,
  output logic      o_tx_ack,
  output logic      o_rx_start,
  output logic      o_rx_done
);
  logic [2:0] tx_cnt_q;  // Cycles left in the frame
  logic [1:0] rx_cnt_q;  // Cycles left in the reception
  // -----------------------------------
  // Frame timing
  // -----------------------------------
  always_ff @(posedge i_mclk) begin
    o_tx_done  <= 1'b0;
    o_rx_start <= 1'b0;
    o_rx_done  <= 1'b0;
    if (!i_rstn) begin
      tx_cnt_q <= 3'h0;
      rx_cnt_q <= 2'h0;
      o_tx_ack <= 1'b0;
    end else begin
      if (i_tx_start) tx_cnt_q <= 3'h4;
      else if (tx_cnt_q != 3'h0) tx_cnt_q <= tx_cnt_q - 3'h1;
      // Ack only means something beside done, so it wanders otherwise
      if (tx_cnt_q == 3'h1) begin
        o_tx_done <= 1'b1;
        o_tx_ack  <= i_ack_val;
      end else o_tx_ack <= ~o_tx_ack;
      if (i_rx_go && i_rx_armed) begin
        o_rx_start <= 1'b1;
        rx_cnt_q   <= 2'h2;
      end else if (rx_cnt_q != 2'h0) rx_cnt_q <= rx_cnt_q - 2'h1;
      if (rx_cnt_q == 2'h1) o_rx_done <= 1'b1;
    end
  end
endmodule // net_engine_model

// ===== sim/tb_top.sv
// Self-checking bench for the command chaining queue.
// Assumes the engine model above answers start requests.
`timescale 1ns/1ps
`define CHK(nm,e,g) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  logic I_MCLK = 1'b0, I_RSTN = 1'b0, I_CHAIN_EN = 1'b0, I_MASK_TA = 1'b0, I_MASK_RI = 1'b0, ack_val = 1'b1;
  logic [7:0] pulse = 8'h00;  // One bit per command or event
  logic [2:0] I_CMD_PAGE = 3'h0;
  logic tx_done, tx_ack, rx_start, rx_done, tx_start, rx_armed, irq, ta, ri, fl_tx, fl_rx, ack, tx_pend;
  logic [2:0] tx_page, rx_page, rx_dpage;
  int num_errors = 0, n_tests = 0, n;
  always #50 I_MCLK = ~I_MCLK;
  command_chain_queue dut (.I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_CHAIN_EN(I_CHAIN_EN), .I_MASK_TA(I_MASK_TA),
    .I_MASK_RI(I_MASK_RI), .I_CMD_TX_EN(pulse[0]), .I_CMD_RX_EN(pulse[1]), .I_CMD_PAGE(I_CMD_PAGE),
    .I_CMD_TX_DIS(pulse[2]), .I_CMD_RX_DIS(pulse[3]), .I_CMD_CLR_TX(pulse[4]), .I_CMD_CLR_RX(pulse[5]),
    .I_TOKEN(pulse[6]), .I_TX_DONE(tx_done), .I_TX_ACK(tx_ack), .I_RX_START(rx_start), .I_RX_DONE(rx_done),
    .O_CHAINING(), .O_TX_START(tx_start), .O_TX_PEND(tx_pend), .O_TX_PAGE(tx_page), .O_RX_ARMED(rx_armed),
    .O_RX_PAGE(rx_page), .O_TX_DONE_EDGE(fl_tx), .O_TX_ACK(ack), .O_TA(ta), .O_RX_DONE_EDGE(fl_rx),
    .O_RX_DONE_PAGE(rx_dpage), .O_RI(ri), .O_IRQ(irq));
  net_engine_model eng (.i_mclk(I_MCLK), .i_rstn(I_RSTN), .i_tx_start(tx_start), .i_ack_val(ack_val),
    .i_rx_go(pulse[7]), .i_rx_armed(rx_armed), .o_tx_done(tx_done), .o_tx_ack(tx_ack),
    .o_rx_start(rx_start), .o_rx_done(rx_done));
  // Settled sampling point after each edge
  task step(input int c);
    repeat (c) begin @(posedge I_MCLK); #1; end
  endtask
  // One-cycle command pulse: 0 tx_en 1 rx_en 2 tx_dis 3 rx_dis 4 clr_tx 5 clr_rx 6 token 7 rx_go
  task cmd(input int k, input logic [2:0] pg);
    @(posedge I_MCLK);
    pulse      <= 8'h01 << k;
    I_CMD_PAGE <= pg;
    @(posedge I_MCLK);
    pulse <= 8'h00;
    #1;
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------
  // Watchdog, far beyond the sequence
  // ----------------------------------
  initial begin
    repeat (5000) @(posedge I_MCLK);
    num_errors++;
    final_report;
  end
  initial begin
    step(5);
    I_RSTN <= 1'b1;
    step(2);
    `CHK("chaining", 1'b0, dut.O_CHAINING)
    `CHK("flags", 4'h3, {fl_tx, fl_rx, ta, ri})
    I_CHAIN_EN <= 1'b1;
    I_MASK_TA  <= 1'b1;
    I_MASK_RI  <= 1'b1;
    step(2);
    `CHK("chaining", 1'b1, dut.O_CHAINING)
    cmd(0, 3'h5);
    cmd(0, 3'h2);
    `CHK("tx queued", 5'h5, {ta, ack, tx_page})
    `CHK("tx pend", 1'b1, tx_pend)
    cmd(6, 3'h0);
    for (n = 0; n < 20 && fl_tx !== 1'b1; n++) step(1);
    step(2);
    `CHK("tx1 status", 6'h3a, {fl_tx, ack, irq, tx_page})
    ack_val <= 1'b0;
    cmd(6, 3'h0);
    step(10);
    `CHK("tx2 held", 4'hf, {fl_tx, ack, irq, ta})
    cmd(4, 3'h0);
    for (n = 0; n < 10 && irq !== 1'b0; n++) step(1);
    for (n = 0; n < 10 && irq !== 1'b1; n++) step(1);
    `CHK("irq gap", 1'b1, n >= 2 && n < 10)
    `CHK("tx2 status", 2'h2, {fl_tx, ack})
    cmd(4, 3'h0);
    step(3);
    `CHK("tx clear", 2'h0, {fl_tx, irq})
    cmd(4, 3'h0);
    step(3);
    `CHK("clr empty", 3'h1, {fl_tx, irq, ta})
    cmd(0, 3'h1);
    cmd(0, 3'h3);
    cmd(2, 3'h0);
    `CHK("tx dis", 3'h3, tx_page)
    cmd(2, 3'h0);
    `CHK("tx dis2", 1'b1, ta)
    cmd(1, 3'h4);
    cmd(1, 3'h6);
    `CHK("rx queued", 4'h4, {ri, rx_page})
    cmd(7, 3'h0);
    for (n = 0; n < 20 && fl_rx !== 1'b1; n++) step(1);
    `CHK("rx1", 4'hc, {fl_rx, rx_dpage})
    cmd(7, 3'h0);
    step(6);
    `CHK("rx held", 5'h1c, {fl_rx, irq, rx_dpage})
    cmd(5, 3'h0);
    step(5);
    `CHK("rx2", 4'he, {fl_rx, rx_dpage})
    cmd(5, 3'h0);
    step(4);
    `CHK("rx clear", 3'h1, {fl_rx, irq, ri})
    cmd(1, 3'h1);
    cmd(1, 3'h2);
    cmd(3, 3'h0);
    `CHK("rx dis", 4'h2, {ri, rx_page})
    cmd(3, 3'h0);
    `CHK("rx dis2", 1'b1, ri)
    final_report;
  end
endmodule // tb_top

// ===== verilog/chain_fifo2.sv
// Two-entry FIFO with a registered head, used for commands and status.
// Assumes push and pop are single-cycle strobes on the device clock.
`timescale 1ns/1ps
module chain_fifo2 #(
  parameter int W = 1                        // Entry width
) (
  input  wire logic                       i_mclk,
  input  wire logic                       i_rstn,
  input  wire logic                       i_push,   // Store an entry
  input  wire logic [W-1:0]               i_data,   // Entry to store
  input  wire logic                       i_pop,    // Drop the oldest
  output logic [W-1:0]                    o_head,   // Oldest entry
  output logic [chain_pkg::CNT_W-1:0]     o_count,  // Occupancy
  output logic                            o_empty,  // No entry held
  output logic                            o_full    // Both entries held
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [W-1:0]               e0_q;      // Oldest entry
  logic [W-1:0]               e1_q;      // Newer entry
  logic [chain_pkg::CNT_W-1:0] cnt_q;    // Entries held
  wire                        push_ok;   // Push that fits
  wire                        pop_ok;    // Pop of a real entry

  // A push into a full FIFO only fits when a pop frees a slot
  assign pop_ok  = i_pop & (cnt_q != chain_pkg::CNT_RST);
  assign push_ok = i_push & ((cnt_q != chain_pkg::CNT_FULL) | pop_ok);
  assign o_head  = e0_q;
  assign o_count = cnt_q;
  assign o_empty = (cnt_q == chain_pkg::CNT_RST);
  assign o_full  = (cnt_q == chain_pkg::CNT_FULL);

  // Shift register update
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      e0_q  <= '0;
      e1_q  <= '0;
      cnt_q <= chain_pkg::CNT_RST;
    end else begin
      unique case ({push_ok, pop_ok})
        2'b10: begin
          // Fill the first free slot
          if (cnt_q == chain_pkg::CNT_RST) e0_q <= i_data;
          else e1_q <= i_data;
          cnt_q <= cnt_q + 2'h1;
        end
        2'b01: begin
          // Drop the oldest
          e0_q  <= e1_q;
          cnt_q <= cnt_q - 2'h1;
        end
        2'b11: begin
          // Swap one in and one out, count unchanged
          if (cnt_q == 2'h1) begin
            e0_q <= i_data;
          end else begin
            e0_q <= e1_q;
            e1_q <= i_data;
          end
        end
        default: ;
      endcase
    end
  end

endmodule // chain_fifo2

// ===== verilog/command_chain_queue.sv
// Command chaining queue: pending page commands and double-buffered
// completion status for transmit and receive, plus the interrupt line.
// Assumes host commands and engine events are one-cycle pulses on I_MCLK.
//
// Functional notes
// - Reset into non-chaining; chaining needs enable bit
// - Chaining accepts two transmit, two receive commands
// - Two completion statuses stored per direction
// - Done flags set only by completions
// - Available and inhibited flags show present state
// - First transmit enable clears available and acknowledge; in chaining only available is cleared
// - Second transmit enable queued with its page
// - Transmit completion sets flag, interrupt, acknowledge
// - Only clear-transmit command clears flag, interrupt
// - Second transmit interrupt waits for clear
// - Interrupt stays low at least three cycles between assertions
// - Acknowledge double-buffered, never raises interrupt
// - Queued transmit starts on next token; in chaining it waits while both statuses are held
// - After clear, second transmit status then interrupt
// - Transmit mask gates only transmit done flag
// - Disable-transmitter cancels oldest queued transmission
// - Receive completion sets flag and interrupt
// - Only clear-receive clears; receive status double-buffered
// - Second receive page used, reported after clear
// - Receive mask gates only receive done flag
// - Disable-receiver cancels oldest unless already receiving
// - Acknowledged transmission sets acknowledge and available
`timescale 1ns/1ps
module command_chain_queue (
  input  wire logic                          I_MCLK,          // Device clock
  input  wire logic                          I_RSTN,          // Sync reset, low
  input  wire logic                          I_CHAIN_EN,      // Chaining enable bit
  input  wire logic                          I_MASK_TA,       // Transmit mask bit
  input  wire logic                          I_MASK_RI,       // Receive mask bit
  input  wire logic                          I_CMD_TX_EN,     // Enable transmit
  input  wire logic                          I_CMD_RX_EN,     // Enable receive
  input  wire logic [chain_pkg::PAGE_W-1:0]  I_CMD_PAGE,      // Page for enables
  input  wire logic                          I_CMD_TX_DIS,    // Disable transmitter
  input  wire logic                          I_CMD_RX_DIS,    // Disable receiver
  input  wire logic                          I_CMD_CLR_TX,    // Clear transmit int
  input  wire logic                          I_CMD_CLR_RX,    // Clear receive int
  input  wire logic                          I_TOKEN,         // Token arrived
  input  wire logic                          I_TX_DONE,       // Transmission over
  input  wire logic                          I_TX_ACK,        // With I_TX_DONE
  input  wire logic                          I_RX_START,      // Reception begun
  input  wire logic                          I_RX_DONE,       // Packet stored
  output logic                               O_CHAINING,      // Chaining active
  output logic                               O_TX_START,      // Begin transmission
  output logic                               O_TX_PEND,       // Transmit queued
  output logic [chain_pkg::PAGE_W-1:0]       O_TX_PAGE,       // Page to send
  output logic                               O_RX_ARMED,      // Receive queued
  output logic [chain_pkg::PAGE_W-1:0]       O_RX_PAGE,       // Page to fill
  output logic                               O_TX_DONE_EDGE,  // Transmit done flag
  output logic                               O_TX_ACK,        // Acknowledge flag
  output logic                               O_TA,            // Transmitter available
  output logic                               O_RX_DONE_EDGE,  // Receive done flag
  output logic [chain_pkg::PAGE_W-1:0]       O_RX_DONE_PAGE,  // Oldest filled page
  output logic                               O_RI,            // Receiver inhibited
  output logic                               O_IRQ            // Interrupt, high
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic                           chain_q;      // Chaining mode
  logic                           tx_run_q;     // Head transmission started
  logic                           rx_run_q;     // Head reception started
  logic                           tmaq_q;       // Plain-mode acknowledge
  logic                           irq_q;        // Interrupt output
  logic [chain_pkg::GAP_W-1:0]    gap_q;        // Interrupt low-time counter
  logic [chain_pkg::GAP_W-1:0]    tx_hold_q;    // Hide after transmit clear
  logic [chain_pkg::GAP_W-1:0]    rx_hold_q;    // Hide after receive clear
  logic [chain_pkg::CNT_W-1:0]    tx_cnt;       // Transmit commands held
  logic [chain_pkg::CNT_W-1:0]    rx_cnt;       // Receive commands held
  logic                           tx_empty;     // No transmit queued
  logic                           tx_full;      // Two transmits queued
  logic                           rx_empty;     // No receive queued
  logic                           rx_full;      // Two receives queued
  logic                           txs_empty;    // No transmit status
  logic                           txs_full;     // Two transmit statuses
  logic                           rxs_empty;    // No receive status
  logic                           rxs_full;     // Two receive statuses
  logic                           txs_head;     // Oldest acknowledge
  logic [chain_pkg::PAGE_W-1:0]   rxs_head;     // Oldest filled page
  logic [chain_pkg::CNT_W-1:0]    txs_cnt;      // Transmit statuses held
  logic [chain_pkg::CNT_W-1:0]    rxs_cnt;      // Receive statuses held
  wire                            tx_limit;     // Room for another transmit
  wire                            rx_limit;     // Room for another receive
  wire                            tx_push;      // Transmit command taken
  wire                            rx_push;      // Receive command taken
  wire                            tx_pop;       // Head transmit leaves
  wire                            rx_pop;       // Head receive leaves
  wire                            rx_cancel;    // Receive disable honoured
  wire                            txs_push;     // Transmit status stored
  wire                            rxs_push;     // Receive status stored
  wire                            txs_pop;      // Transmit status cleared
  wire                            rxs_pop;      // Receive status cleared
  wire                            tx_flag;      // Visible transmit done flag
  wire                            rx_flag;      // Visible receive done flag
  wire                            irq_raw;      // Masked interrupt request
  wire                            irq_d;        // Next interrupt level

  // ---------------------------------------------------------------
  // Command acceptance
  // ---------------------------------------------------------------
  // Plain mode keeps one command per direction; chaining keeps two
  assign tx_limit  = chain_q ? !tx_full : tx_empty;
  assign rx_limit  = chain_q ? !rx_full : rx_empty;
  assign tx_push   = I_CMD_TX_EN & tx_limit;
  assign rx_push   = I_CMD_RX_EN & rx_limit;
  // Oldest command leaves on its completion or on a disable
  assign tx_pop    = I_TX_DONE | I_CMD_TX_DIS;
  // A reception already under way is not cancelled
  assign rx_cancel = I_CMD_RX_DIS & !rx_run_q;
  assign rx_pop    = I_RX_DONE | rx_cancel;

  // ---------------------------------------------------------------
  // Status queues, filled only by completions in chaining mode
  // ---------------------------------------------------------------
  assign txs_push = chain_q & I_TX_DONE & !tx_empty;
  assign rxs_push = chain_q & I_RX_DONE & !rx_empty;
  // Clears of an empty queue fall away inside the FIFO
  assign txs_pop  = I_CMD_CLR_TX;
  assign rxs_pop  = I_CMD_CLR_RX;

  // Pending transmit pages
  chain_fifo2 #(.W(chain_pkg::PAGE_W)) u_tx_cmd (
    .i_mclk  (I_MCLK),
    .i_rstn  (I_RSTN),
    .i_push  (tx_push),
    .i_data  (I_CMD_PAGE),
    .i_pop   (tx_pop),
    .o_head  (O_TX_PAGE),
    .o_count (tx_cnt),
    .o_empty (tx_empty),
    .o_full  (tx_full)
  );

  // Pending receive pages
  chain_fifo2 #(.W(chain_pkg::PAGE_W)) u_rx_cmd (
    .i_mclk  (I_MCLK),
    .i_rstn  (I_RSTN),
    .i_push  (rx_push),
    .i_data  (I_CMD_PAGE),
    .i_pop   (rx_pop),
    .o_head  (O_RX_PAGE),
    .o_count (rx_cnt),
    .o_empty (rx_empty),
    .o_full  (rx_full)
  );

  // Transmit acknowledge per completion, double-buffered
  chain_fifo2 #(.W(1)) u_tx_stat (
    .i_mclk  (I_MCLK),
    .i_rstn  (I_RSTN),
    .i_push  (txs_push),
    .i_data  (I_TX_ACK),
    .i_pop   (txs_pop),
    .o_head  (txs_head),
    .o_count (txs_cnt),
    .o_empty (txs_empty),
    .o_full  (txs_full)
  );

  // Filled receive page per completion, double-buffered
  chain_fifo2 #(.W(chain_pkg::PAGE_W)) u_rx_stat (
    .i_mclk  (I_MCLK),
    .i_rstn  (I_RSTN),
    .i_push  (rxs_push),
    .i_data  (O_RX_PAGE),
    .i_pop   (rxs_pop),
    .o_head  (rxs_head),
    .o_count (rxs_cnt),
    .o_empty (rxs_empty),
    .o_full  (rxs_full)
  );

  // ---------------------------------------------------------------
  // Engine handshake
  // ---------------------------------------------------------------
  // Start waits for a free status slot so no result is ever lost
  assign O_TX_START = I_TOKEN & !tx_empty & !tx_run_q
                      & !(chain_q & txs_full);
  assign O_TX_PEND  = !tx_empty;
  assign O_RX_ARMED = !rx_empty & !(chain_q & rxs_full);

  // Chaining mode follows the configuration bit; off after reset
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) chain_q <= 1'b0;
    else chain_q <= I_CHAIN_EN;
  end

  // Head transmission runs from start until it leaves the queue
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) tx_run_q <= 1'b0;
    else if (tx_pop) tx_run_q <= 1'b0;
    else if (O_TX_START) tx_run_q <= 1'b1;
  end

  // Head reception runs from its first byte until it is stored
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) rx_run_q <= 1'b0;
    else if (I_RX_DONE) rx_run_q <= 1'b0;
    else if (I_RX_START & !rx_empty) rx_run_q <= 1'b1;
  end

  // Plain acknowledge: cleared by an enable into an idle queue
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) tmaq_q <= 1'b0;
    else if (I_TX_DONE & !tx_empty) tmaq_q <= I_TX_ACK;
    else if (tx_push & tx_empty) tmaq_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Visible flags
  // ---------------------------------------------------------------
  // A clear hides the flag briefly so the next status shows as a new edge
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      tx_hold_q <= '0;
      rx_hold_q <= '0;
    end else begin
      if (txs_pop & !txs_empty) tx_hold_q <= chain_pkg::GAP_LOAD;
      else if (tx_hold_q != '0) tx_hold_q <= tx_hold_q - 2'h1;
      if (rxs_pop & !rxs_empty) rx_hold_q <= chain_pkg::GAP_LOAD;
      else if (rx_hold_q != '0) rx_hold_q <= rx_hold_q - 2'h1;
    end
  end

  // Done flags stand while a status is held and no clear is settling
  assign tx_flag        = !txs_empty & (tx_hold_q == '0);
  assign rx_flag        = !rxs_empty & (rx_hold_q == '0);
  assign O_TX_DONE_EDGE = tx_flag;
  assign O_RX_DONE_EDGE = rx_flag;
  // Acknowledge belongs to the oldest held status in chaining mode
  assign O_TX_ACK       = chain_q ? (tx_flag & txs_head) : tmaq_q;
  assign O_RX_DONE_PAGE = rxs_head;
  // Present state stays live in both modes
  assign O_TA           = tx_empty;
  assign O_RI           = rx_empty;
  assign O_CHAINING     = chain_q;

  // ---------------------------------------------------------------
  // Interrupt
  // ---------------------------------------------------------------
  // In chaining the masks act on the done flags, not on the levels
  assign irq_raw = chain_q ? ((I_MASK_TA & tx_flag) | (I_MASK_RI & rx_flag))
                           : ((I_MASK_TA & O_TA) | (I_MASK_RI & O_RI));
  assign irq_d   = irq_raw & (gap_q == '0);

  // Each fall of the line starts a guaranteed low interval
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      irq_q <= 1'b0;
      gap_q <= '0;
    end else begin
      irq_q <= irq_d;
      if (irq_q & !irq_d) gap_q <= chain_pkg::GAP_LOAD;
      else if (gap_q != '0) gap_q <= gap_q - 2'h1;
    end
  end
  assign O_IRQ = irq_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);

  // The line stays low for the whole gap after falling
  sequence s_irq_low2;
    !O_IRQ ##1 !O_IRQ;
  endsequence

  a_reset_nonchain: assert property ($rose(I_RSTN) |-> !O_CHAINING)
    else $error("chaining active straight after reset");
  a_tx_two_accept: assert property (chain_q && I_CMD_TX_EN && tx_cnt == 2'h1 && !tx_pop
    |=> tx_cnt == 2'h2)
    else $error("second transmit command not queued");
  a_flag_cause: assert property ($rose(O_TX_DONE_EDGE) |-> $past(txs_push)
    || $past(tx_hold_q) != '0)
    else $error("transmit done flag rose without a completion");
  a_enable_clears: assert property (I_CMD_TX_EN && tx_empty && !I_TX_DONE
    |=> !O_TA && (chain_q || !O_TX_ACK))
    else $error("first enable did not clear available or acknowledge");
  a_clear_only: assert property ($fell(O_TX_DONE_EDGE) |-> $past(I_CMD_CLR_TX))
    else $error("transmit done flag cleared without its command");
  a_irq_gap: assert property ($fell(O_IRQ) |-> s_irq_low2)
    else $error("interrupt inactive time too short");
  a_ack_no_irq: assert property (chain_q && !tx_flag && !rx_flag |=> !O_IRQ)
    else $error("interrupt without a done flag in chaining mode");
  a_token_start: assert property (O_TX_START |-> I_TOKEN && O_TX_PEND ##1 tx_run_q)
    else $error("transmit start without token or queued command");
  a_second_after: assert property (chain_q && txs_cnt == 2'h2 && I_CMD_CLR_TX && !txs_push
    |=> !O_TX_DONE_EDGE ##1 !O_TX_DONE_EDGE ##1 O_TX_DONE_EDGE)
    else $error("second transmit status not presented after clear");
  a_rx_busy_keep: assert property (I_CMD_RX_DIS && rx_run_q && !I_RX_DONE && !rx_push
    |=> rx_cnt == $past(rx_cnt))
    else $error("running reception was cancelled");
  a_clr_empty: assert property (I_CMD_CLR_RX && rxs_empty && !rxs_push
    |=> rxs_empty && rx_cnt == $past(rx_cnt) + {1'b0, $past(rx_push)})
    else $error("clear with no status changed state");

endmodule // command_chain_queue
